// File: fcwl_decode.sv
`timescale 1ns/1ps
// derives wide settings from the packed configuration words
// purely combinational; the top registers the results
module fcwl_decode
(
	input  wire logic [23:0] wordOne,
	input  wire logic [23:0] wordTwo,
	input  wire logic [23:0] wordThree,
	output logic [1:0]       icsSel,
	output logic [15:0]      prescale,
	output logic [15:0]      postscale,
	output logic             windowMode,
	output logic [3:0]       pllDivide,
	output logic             clockOutActive,
	output logic [23:0]      segLow,
	output logic [23:0]      segHigh,
	output logic             segActive
);
	logic [1:0] ics;
	logic [2:0] pll;
	logic [8:0] page;
	logic [23:0] pageBase;

	// pin pair, 01 behaves as pair 2, 00 flagged reserved
	assign ics = wordOne[fcwl_pkg::W1_ICS_LO +: 2];
	always_comb
	begin
		case (ics)
			2'h3:    icsSel = 2'(fcwl_pkg::ICS_PAIR1);
			2'h0:    icsSel = 2'(fcwl_pkg::ICS_BAD);
			default: icsSel = 2'(fcwl_pkg::ICS_PAIR2);
		endcase
	end

	// watchdog ratios
	assign prescale = wordOne[fcwl_pkg::W1_PRESCALE] ? fcwl_pkg::PRESCALE_HI
		: fcwl_pkg::PRESCALE_LO;
	assign postscale = 16'h0001 << wordOne[fcwl_pkg::W1_POST_LO +: 4];
	// window valid only with watchdog enabled
	assign windowMode = !wordOne[fcwl_pkg::W1_WIN_DIS] && wordOne[fcwl_pkg::W1_WDT_EN];

	// pll input divider: 111 is 12, 000 passes through
	assign pll = wordTwo[fcwl_pkg::W2_PLLDIV_LO +: 3];
	always_comb
	begin
		case (pll)
			3'h7:    pllDivide = 4'hc;
			3'h6:    pllDivide = 4'h8;
			3'h5:    pllDivide = 4'h6;
			3'h4:    pllDivide = 4'h5;
			3'h3:    pllDivide = 4'h4;
			3'h2:    pllDivide = 4'h3;
			3'h1:    pllDivide = 4'h2;
			default: pllDivide = 4'h1;
		endcase
	end

	// clock out only where the primary oscillator leaves the pin free
	assign clockOutActive = wordTwo[fcwl_pkg::W2_CLKOUT]
		&& (wordTwo[fcwl_pkg::W2_POSC_LO +: 2] == fcwl_pkg::POSC_OFF
		|| wordTwo[fcwl_pkg::W2_POSC_LO +: 2] == 2'h0);

	// segment bounds from boundary page
	assign page = wordThree[fcwl_pkg::W3_PAGE_LO +: 9];
	assign pageBase = 24'(page) << fcwl_pkg::PAGE_SHIFT; // word address page * 16K
	assign segLow  = wordThree[fcwl_pkg::W3_SEG_END] ? 24'h000000 : pageBase;
	assign segHigh = wordThree[fcwl_pkg::W3_SEG_END] ? pageBase + 24'h003fff
		: fcwl_pkg::CFG_SPACE_LO - 24'h000001;
	assign segActive = !wordThree[fcwl_pkg::W3_SEG_DIS];
endmodule

// File: fcwl_fetch.sv
`timescale 1ns/1ps
// sequences the three configuration word reads
// assumes the flash port holds readValid for one cycle per read
module fcwl_fetch
(
	input  wire logic        clk,
	input  wire logic        reset,
	fcwl_flash_if.fetcher    flash,
	output logic             wordValid,
	output logic [1:0]       wordIndex,
	output logic [23:0]      wordData,
	output logic             done
);
	typedef enum logic [1:0] {ISSUE, WAIT, FINISH} fcwl_fetch_e;
	fcwl_fetch_e state_reg;
	logic [1:0]  idx_reg;

	// ---------------------------------------------------------------
	// read sequencing, word one highest, each next word two lower
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= ISSUE;
			idx_reg <= 2'h0;
		end
		else
		begin
			case (state_reg)
				ISSUE: state_reg <= WAIT;
				WAIT:
					if (flash.readValid)
					begin
						if (idx_reg == 2'h2)
							state_reg <= FINISH;
						else
						begin
							idx_reg <= idx_reg + 2'h1;
							state_reg <= ISSUE;
						end
					end
				FINISH: state_reg <= FINISH;
				default: state_reg <= ISSUE;
			endcase
		end
	end

	// top address minus two per word
	assign flash.readStrobe = (state_reg == ISSUE);
	assign flash.readAddr = fcwl_pkg::WORD1_ADDR - {21'h0, idx_reg, 1'b0};
	assign wordValid = (state_reg == WAIT) && flash.readValid;
	assign wordIndex = idx_reg;
	assign wordData = flash.readData;
	assign done = (state_reg == FINISH);
endmodule

// File: fcwl_flash_if.sv
`timescale 1ns/1ps
// flash read port carried between loader and fetch unit
// assumes the flash answers one cycle after a read strobe
interface fcwl_flash_if;
	logic        readStrobe;
	logic [23:0] readAddr;
	logic        readValid;
	logic [23:0] readData;
	modport fetcher (output readStrobe, output readAddr, input readValid, input readData);
	modport array (input readStrobe, input readAddr, output readValid, output readData);
endinterface

// File: fcwl_flash_model.sv
`timescale 1ns/1ps
// behavioural program flash holding the three configuration words
// assumes one strobe at a time; answers after lat cycles (1 = prompt)
module fcwl_flash_model
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        flashReadStrobe,
	input  wire logic [23:0] flashReadAddr,
	output logic             flashReadValid,
	output logic [23:0]      flashReadData,
	input  wire logic [23:0] wordOne,
	input  wire logic [23:0] wordTwo,
	input  wire logic [23:0] wordThree,
	input  wire logic [3:0]  lat
);
	logic [3:0]  cnt;
	logic [23:0] addr;
	// -----------------------------------------------------------------
	// read answer
	// -----------------------------------------------------------------
	// idle data toggles so a loader that samples it outside valid fails
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cnt <= 4'h0;
			flashReadValid <= 1'b0;
			flashReadData <= 24'h5a5a5a;
		end
		else
		begin
			flashReadValid <= 1'b0;
			flashReadData <= ~flashReadData;
			if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
			if (cnt == 4'h1)
			begin
				flashReadValid <= 1'b1;
				flashReadData <= (addr == 24'h02abfe) ? wordOne :
					(addr == 24'h02abfc) ? wordTwo :
					(addr == 24'h02abfa) ? wordThree : 24'hffffff;
			end
			if (flashReadStrobe)
			begin
				cnt <= lat;
				addr <= flashReadAddr;
			end
		end
	end
endmodule

// File: fcwl_loader.sv
`timescale 1ns/1ps
// top of the flash configuration word loader: fetches the three
// packed words after every reset, keeps them as volatile copies and
// registers the decoded settings for the dependent units
// assumes reset covers every device reset kind, that the flash array
// answers reads on the plain ports below, and that the dependent units
// wait for deviceResetRelease before they act on any setting
module fcwl_loader
(
	input  wire logic        clk,
	input  wire logic        reset,
	// flash array read port
	output logic             flashReadStrobe,
	output logic [23:0]      flashReadAddr,
	input  wire logic        flashReadValid,
	input  wire logic [23:0] flashReadData,
	// programming path: serial path may change scan enable, scan path not
	input  wire logic        progViaSerial,
	// table access into configuration space
	input  wire logic        tableRead,
	input  wire logic [23:0] tableAddr,
	output logic [23:0]      tableData,
	// decoded settings
	output logic             loadDone,
	output logic             deviceResetRelease,
	output logic             scanPortEnable,
	output logic             wholeCodeProtect,
	output logic             wholeWriteProtect,
	output logic             debugModeEntry,
	output logic [1:0]       emulatorPinPairSelect,
	output logic             watchdogEnableCfg,
	output logic             watchdogWindowed,
	output logic [15:0]      watchdogPrescale,
	output logic [15:0]      watchdogPostscale,
	output logic             twoSpeedStartupEnable,
	output logic [3:0]       usbPllInputDivider,
	output logic             clockOutPinFunction,
	output logic             usbRegulatorDisable,
	output logic [1:0]       primaryOscMode,
	output logic             segmentProtectEnable,
	output logic             protectLastPageConfig,
	output logic [23:0]      protectSegmentLow,
	output logic [23:0]      protectSegmentHigh
);
	logic [23:0] configWordOne_reg;
	logic [23:0] configWordTwo_reg;
	logic [23:0] configWordThree_reg;
	logic        scanEnableHeld_reg;
	logic        wordValid;
	logic [1:0]  wordIndex;
	logic [23:0] wordData;
	logic        fetchDone;
	logic [1:0]  icsSel;
	logic [15:0] prescale;
	logic [15:0] postscale;
	logic        windowMode;
	logic [3:0]  pllDivide;
	logic        clockOutActive;
	logic [23:0] segLow;
	logic [23:0] segHigh;
	logic        segActive;
	logic [23:0] tableIndex;

	fcwl_flash_if flashBus ();

	// ---------------------------------------------------------------
	// flash port and fetch sequencing
	// ---------------------------------------------------------------
	// strobe and address leave through flip-flops, one cycle behind the
	// fetch unit; it simply waits that cycle longer for the answer, and
	// the array never sees a decode glitch on its strobe
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			flashReadStrobe <= 1'b0;
			flashReadAddr <= fcwl_pkg::WORD1_ADDR;
		end
		else
		begin
			flashReadStrobe <= flashBus.readStrobe;
			flashReadAddr <= flashBus.readAddr;
		end
	end

	// answers go straight in; fetch only looks at them while waiting
	assign flashBus.readValid = flashReadValid;
	assign flashBus.readData = flashReadData;

	// fetch walks the three words down from the top of flash, one
	// outstanding read at a time, and then parks in its finish state
	fcwl_fetch fetch (
		.clk       (clk),
		.reset     (reset),
		.flash     (flashBus),
		.wordValid (wordValid),
		.wordIndex (wordIndex),
		.wordData  (wordData),
		.done      (fetchDone)
	);

	// decode follows the held words continuously; its results reach the
	// pins only through the registers below, after the load is done
	fcwl_decode decode (
		.wordOne        (configWordOne_reg),
		.wordTwo        (configWordTwo_reg),
		.wordThree      (configWordThree_reg),
		.icsSel         (icsSel),
		.prescale       (prescale),
		.postscale      (postscale),
		.windowMode     (windowMode),
		.pllDivide      (pllDivide),
		.clockOutActive (clockOutActive),
		.segLow         (segLow),
		.segHigh        (segHigh),
		.segActive      (segActive)
	);

	// ---------------------------------------------------------------
	// volatile configuration words
	// ---------------------------------------------------------------
	// the upper byte holds no configuration bits; forcing it to ones
	// means a table read shows what an erased location would hold there
	function automatic logic [23:0] packWord(input logic [23:0] data);
		packWord = {8'hff, data[15:0]};
	endfunction

	// reset returns to erased defaults, then the words are reloaded;
	// the upper byte is forced to ones since no bits live there
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			configWordOne_reg <= fcwl_pkg::ERASED_WORD;
			configWordTwo_reg <= fcwl_pkg::ERASED_WORD;
			configWordThree_reg <= fcwl_pkg::ERASED_WORD;
		end
		else if (wordValid)
		begin
			case (wordIndex)
				2'h0: configWordOne_reg <= packWord(wordData);
				2'h1: configWordTwo_reg <= packWord(wordData);
				2'h2: configWordThree_reg <= packWord(wordData);
				default: configWordOne_reg <= configWordOne_reg;
			endcase
		end
	end

	// scan enable is latched only on a serial-path load, so a scan-port
	// programming session cannot lock itself out; default enabled
	// the held copy returns to enabled on every reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			scanEnableHeld_reg <= 1'b1;
		else if (wordValid && wordIndex == 2'h0 && progViaSerial)
			scanEnableHeld_reg <= wordData[fcwl_pkg::W1_SCAN_EN];
	end

	// ---------------------------------------------------------------
	// table read into configuration space
	// ---------------------------------------------------------------
	// word N sits at base + 2*N; outside the space reads as erased.
	// tableRead is a one-cycle pulse and tableData stands until the
	// next one; reads before the load finishes show erased copies of the words
	// not yet fetched, which is what software would see of a blank part anyway
	assign tableIndex = tableAddr - fcwl_pkg::CFG_BASE_ADDR;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			tableData <= fcwl_pkg::ERASED_WORD;
		else if (tableRead)
		begin
			if (tableAddr < fcwl_pkg::CFG_SPACE_LO)
				tableData <= fcwl_pkg::ERASED_WORD;
			else if (tableIndex == 24'h000000)
				tableData <= configWordOne_reg;
			else if (tableIndex == fcwl_pkg::WORD_STEP)
				tableData <= configWordTwo_reg;
			else if (tableIndex == 24'h000004)
				tableData <= configWordThree_reg;
			else
				tableData <= fcwl_pkg::ERASED_WORD;
		end
	end

	// ---------------------------------------------------------------
	// load status
	// ---------------------------------------------------------------
	// dependent units stay in reset until done, so none of them acts on
	// words left over from before this reset; done stays up until the
	// next reset, since the words cannot change in between
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			loadDone <= 1'b0;
			deviceResetRelease <= 1'b0;
		end
		else if (fetchDone)
		begin
			loadDone <= 1'b1;
			deviceResetRelease <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// test port, debugger entry and emulator pins
	// ---------------------------------------------------------------
	// closed test port and normal start while loading: a half-loaded
	// word must never open the scan port or stall the core in debug
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			scanPortEnable <= 1'b0;
			debugModeEntry <= 1'b0;
			emulatorPinPairSelect <= 2'(fcwl_pkg::ICS_PAIR1);
		end
		else if (fetchDone)
		begin
			scanPortEnable <= scanEnableHeld_reg;
			debugModeEntry <= !configWordOne_reg[fcwl_pkg::W1_DEBUG];
			emulatorPinPairSelect <= icsSel;
		end
	end

	// ---------------------------------------------------------------
	// code and write protection
	// ---------------------------------------------------------------
	// whole-memory protection is on while loading, the safe side for a
	// reader that ignores the release; segment bounds only mean
	// something once segmentProtectEnable is up
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wholeCodeProtect <= 1'b1;
			wholeWriteProtect <= 1'b1;
			segmentProtectEnable <= 1'b0;
			protectLastPageConfig <= 1'b0;
			protectSegmentLow <= 24'h000000;
			protectSegmentHigh <= 24'h000000;
		end
		else if (fetchDone)
		begin
			// erased last page gives zeros, leaving protection off
			wholeCodeProtect <= !configWordOne_reg[fcwl_pkg::W1_CODE_PROT];
			wholeWriteProtect <= !configWordOne_reg[fcwl_pkg::W1_WRITE_PROT];
			segmentProtectEnable <= segActive;
			protectLastPageConfig <= !configWordThree_reg[fcwl_pkg::W3_LAST_PAGE];
			protectSegmentLow <= segLow;
			protectSegmentHigh <= segHigh;
		end
	end

	// ---------------------------------------------------------------
	// watchdog configuration
	// ---------------------------------------------------------------
	// watchdog off while loading; the window bit alone cannot turn on
	// windowed mode, the decode already ties it to the enable
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			watchdogEnableCfg <= 1'b0;
			watchdogWindowed <= 1'b0;
			watchdogPrescale <= fcwl_pkg::PRESCALE_HI;
			watchdogPostscale <= 16'h0001;
		end
		else if (fetchDone)
		begin
			watchdogEnableCfg <= configWordOne_reg[fcwl_pkg::W1_WDT_EN];
			watchdogWindowed <= windowMode;
			watchdogPrescale <= prescale;
			watchdogPostscale <= postscale;
		end
	end

	// ---------------------------------------------------------------
	// oscillator, clock output and usb supply
	// ---------------------------------------------------------------
	// primary oscillator and usb regulator off while loading, so nothing
	// starts on a guessed setting; the clock units must still wait for
	// the release before switching
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			twoSpeedStartupEnable <= 1'b0;
			usbPllInputDivider <= 4'h1;
			clockOutPinFunction <= 1'b0;
			usbRegulatorDisable <= 1'b1;
			primaryOscMode <= fcwl_pkg::POSC_OFF;
		end
		else if (fetchDone)
		begin
			twoSpeedStartupEnable <= configWordTwo_reg[fcwl_pkg::W2_TWO_SPEED];
			usbPllInputDivider <= pllDivide;
			clockOutPinFunction <= clockOutActive;
			usbRegulatorDisable <= configWordTwo_reg[fcwl_pkg::W2_USBREG_DIS];
			primaryOscMode <= configWordTwo_reg[fcwl_pkg::W2_POSC_LO +: 2];
		end
	end
endmodule

// File: fcwl_loader_checker.sv
`timescale 1ns/1ps
// port assertions for the configuration loader
// bound to fcwl_loader; sees only its top ports
module fcwl_loader_checker
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        flashReadStrobe,
	input wire logic [23:0] flashReadAddr,
	input wire logic        tableRead,
	input wire logic [23:0] tableData,
	input wire logic        loadDone,
	input wire logic        deviceResetRelease,
	input wire logic        wholeCodeProtect,
	input wire logic        wholeWriteProtect,
	input wire logic [15:0] watchdogPrescale,
	input wire logic [15:0] watchdogPostscale,
	input wire logic [1:0]  primaryOscMode
);
	logic [23:0] lastAddr;
	logic [7:0]  waitCnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// -----------------------------------------------------------------
	// helpers: last strobed address, cycles spent loading
	// -----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			lastAddr <= 24'h000000;
		else if (flashReadStrobe)
			lastAddr <= flashReadAddr;
	end
	// saturates so a hung load keeps failing
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			waitCnt <= 8'h00;
		else if (!loadDone && waitCnt != 8'hff)
			waitCnt <= waitCnt + 8'h01;
	end
	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	a_fetch_order: assert property (flashReadStrobe |->
		(flashReadAddr == 24'h02abfe && lastAddr == 24'h000000) ||
		(flashReadAddr == 24'h02abfc && lastAddr == 24'h02abfe) ||
		(flashReadAddr == 24'h02abfa && lastAddr == 24'h02abfc)) else $error("fetch order");
	a_release_follows_load: assert property (deviceResetRelease == loadDone)
		else $error("release not tied to load");
	a_done_sticks: assert property (loadDone |=> loadDone) else $error("done dropped");
	a_no_late_fetch: assert property (loadDone |-> !flashReadStrobe)
		else $error("fetch after done");
	a_load_bounded: assert property (waitCnt <= 8'd60) else $error("load too long");
	a_protect_until_done: assert property (!loadDone |-> wholeCodeProtect && wholeWriteProtect)
		else $error("protection open before load");
	a_settings_hold: assert property (loadDone && $past(loadDone) |->
		$stable(watchdogPostscale) && $stable(primaryOscMode)) else $error("settings moved");
	a_prescale_legal: assert property (loadDone |->
		watchdogPrescale == 16'h0080 || watchdogPrescale == 16'h0020) else $error("bad prescale");
	a_post_onehot: assert property (loadDone |-> $onehot(watchdogPostscale))
		else $error("postscale not power of two");
	a_table_upper: assert property (tableRead |=> tableData[23:16] == 8'hff)
		else $error("table upper byte");
	c_load: cover property ($rose(loadDone));
	c_table: cover property (tableRead && loadDone);
	c_wdt_small: cover property (loadDone && watchdogPrescale == 16'h0020);
endmodule

// File: fcwl_pkg.sv
// package of constants for the flash configuration word loader
// assumes a single 10 MHz clock and a word-wide flash read port
package fcwl_pkg;
	localparam int ADDR_W = 24;
	localparam int WORD_W = 24;
	localparam logic [23:0] CFG_SPACE_LO  = 24'h800000;
	localparam logic [23:0] CFG_SPACE_HI  = 24'hffffff;
	localparam logic [23:0] CFG_BASE_ADDR = 24'hf80000;
	localparam logic [23:0] WORD1_ADDR    = 24'h02abfe;
	localparam logic [23:0] WORD_STEP     = 24'h000002;
	localparam logic [23:0] ERASED_WORD   = 24'hffffff;
	// word one fields
	localparam int W1_SCAN_EN = 14;
	localparam int W1_CODE_PROT = 13;
	localparam int W1_WRITE_PROT = 12;
	localparam int W1_DEBUG = 11;
	localparam int W1_ICS_LO = 8;
	localparam int W1_WDT_EN = 7;
	localparam int W1_WIN_DIS = 6;
	localparam int W1_PRESCALE = 4;
	localparam int W1_POST_LO = 0;
	// word two fields
	localparam int W2_TWO_SPEED = 15;
	localparam int W2_PLLDIV_LO = 12;
	localparam int W2_CLKOUT = 5;
	localparam int W2_USBREG_DIS = 3;
	localparam int W2_POSC_LO = 0;
	// word three fields
	localparam int W3_SEG_END = 15;
	localparam int W3_LAST_PAGE = 14;
	localparam int W3_SEG_DIS = 13;
	localparam int W3_PAGE_LO = 0;
	localparam int PAGE_SHIFT = 14; // 16K-word pages
	localparam logic [1:0] ICS_RESERVED = 2'h0;
	localparam logic [1:0] POSC_OFF = 2'h3;
	localparam logic [15:0] PRESCALE_HI = 16'h0080;
	localparam logic [15:0] PRESCALE_LO = 16'h0020;
	typedef enum logic [1:0] {ICS_PAIR1, ICS_PAIR2, ICS_BAD} fcwl_ics_e;
endpackage

// File: tb_fcwl_loader.sv
`timescale 1ns/1ps
// self-checking bench for the configuration loader with a flash model
// assumes the loader answers per its hand-over timing
module tb_fcwl_loader;
	logic clk = 1'b0, reset = 1'b1, rdStb, rdValid, progViaSerial = 1'b1, tableRead = 1'b0;
	logic loadDone, rel, scan, whole_code_protect, gwp, dbg, wdt, win, two, clock_output_pin, usbD, segEn, lastP;
	logic [23:0] rdAddr, rdData, tableAddr = 24'h0, tableData, segLo, segHi;
	logic [23:0] w1 = 24'hffffff, w2 = 24'hffffff, w3 = 24'hffffff;
	logic [15:0] pre, post;
	logic [3:0]  lat = 4'h1, pll;
	logic [1:0]  ics, osc;
	int nMismatch = 0, nTests = 0, cyc = 0;
	always #50 clk = ~clk;
	fcwl_loader i_dut (.clk, .reset, .flashReadStrobe(rdStb), .flashReadAddr(rdAddr),
		.flashReadValid(rdValid), .flashReadData(rdData), .progViaSerial, .tableRead,
		.tableAddr, .tableData, .loadDone, .deviceResetRelease(rel), .scanPortEnable(scan),
		.wholeCodeProtect(whole_code_protect), .wholeWriteProtect(gwp), .debugModeEntry(dbg),
		.emulatorPinPairSelect(ics), .watchdogEnableCfg(wdt), .watchdogWindowed(win),
		.watchdogPrescale(pre), .watchdogPostscale(post), .twoSpeedStartupEnable(two),
		.usbPllInputDivider(pll), .clockOutPinFunction(clock_output_pin), .usbRegulatorDisable(usbD),
		.primaryOscMode(osc), .segmentProtectEnable(segEn), .protectLastPageConfig(lastP),
		.protectSegmentLow(segLo), .protectSegmentHigh(segHi));
	fcwl_flash_model i_flash (.clk, .reset, .flashReadStrobe(rdStb), .flashReadAddr(rdAddr),
		.flashReadValid(rdValid), .flashReadData(rdData), .wordOne(w1), .wordTwo(w2),
		.wordThree(w3), .lat);
	// -----------------------------------------------------------------
	// shared tasks
	// -----------------------------------------------------------------
	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		nTests++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic testDone();
		$display("mismatches %0d of %0d checks", nMismatch, nTests);
		if (nMismatch == 0 && nTests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// reset with new flash contents, then wait for the load
	task automatic load(input logic [23:0] a, b, c, input logic [3:0] l, input logic s);
		int k;
		w1 <= a;
		w2 <= b;
		w3 <= c;
		lat <= l;
		progViaSerial <= s;
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		k = 0;
		while (loadDone !== 1'b1 && k < 100)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("release", 24'h1, {23'h0, rel});
		@(posedge clk);
	endtask
	task automatic tread(input logic [23:0] a, input logic [23:0] exp);
		tableRead <= 1'b1;
		tableAddr <= a;
		@(posedge clk);
		tableRead <= 1'b0;
		#1;
		chk("tableData", exp, tableData);
		@(posedge clk);
	endtask
	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic tErased();
		load(24'hffffff, 24'hffffff, 24'hffffff, 4'h1, 1'b1);
		chk("protect", 24'h0, {whole_code_protect, gwp, segEn, lastP});
		chk("flags", 24'h2f, {dbg, wdt, win, two, clock_output_pin, usbD, scan});
		chk("pre", {8'h0, fcwl_pkg::PRESCALE_HI}, {8'h0, pre});
		chk("seg", {24'h0}, segLo);
		chk("segHi", 24'h7fffff, segHi);
		$display("erased words done");
	endtask
	task automatic tProgrammed();
		load(24'hff0100, 24'hff0000, 24'hff9e03, 4'h3, 1'b1);
		chk("protect", 24'hf, {whole_code_protect, gwp, segEn, lastP});
		chk("flags", 24'h40, {dbg, wdt, win, two, clock_output_pin, usbD, scan});
		chk("pre", {8'h0, fcwl_pkg::PRESCALE_LO}, {8'h0, pre});
		chk("segHi", 24'h00ffff, segHi);
		tread(fcwl_pkg::CFG_BASE_ADDR, 24'hff0100);
		tread(fcwl_pkg::CFG_BASE_ADDR + 24'h2, 24'hff0000);
		tread(fcwl_pkg::CFG_BASE_ADDR + 24'h4, 24'hff9e03);
		tread(fcwl_pkg::CFG_BASE_ADDR + 24'h6, 24'hffffff);
		tread(24'h7ffffe, 24'hffffff);
		$display("programmed words done");
	endtask
	// scan enable cleared in flash but written over the scan path
	task automatic tScanHold();
		load(24'h00bfff, 24'hffffff, 24'hff1e05, 4'h2, 1'b0);
		chk("scan", 24'h1, {23'h0, scan});
		chk("segLo", 24'h014000, segLo);
		chk("segHi", 24'h7fffff, segHi);
		chk("prot", 24'h3, {segEn, lastP});
		$display("scan hold done");
	endtask
	task automatic tFields();
		logic [3:0] pllExp[8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hc};
		logic [1:0] icsExp[4] = '{2'h2, 2'h1, 2'h1, 2'h0};
		for (int i = 0; i < 16; i++)
		begin
			// bit 6 follows i[2] for windowed mode, bit 4 follows i[0]
			load({14'h3fff, i[1:0], 1'b1, i[2], 1'b1, i[0], i[3:0]},
				{9'h1ff, i[2:0], 10'h3ff, i[1:0]}, 24'hffffff, 4'(i % 3 + 1), 1'b1);
			chk("post", {8'h0, 16'h1 << i}, {8'h0, post});
			chk("ics", {22'h0, icsExp[i[1:0]]}, {22'h0, ics});
			chk("pll", {20'h0, pllExp[i[2:0]]}, {20'h0, pll});
			chk("osc", {22'h0, i[1:0]}, {22'h0, osc});
			chk("win", {23'h0, !i[2]}, {23'h0, win});
			chk("pre", {8'h0, i[0] ? fcwl_pkg::PRESCALE_HI : fcwl_pkg::PRESCALE_LO}, {8'h0, pre});
			chk("clock_output_pin", {23'h0, i[1:0] == 2'h3 || i[1:0] == 2'h0}, {23'h0, clock_output_pin});
		end
		$display("field sweep done");
	endtask
	// -----------------------------------------------------------------
	// main sequence and timeout
	// -----------------------------------------------------------------
	initial
	begin
		@(posedge clk);
		tErased();
		tProgrammed();
		tScanHold();
		tFields();
		testDone();
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			nMismatch++;
			testDone();
		end
	end
endmodule
bind fcwl_loader fcwl_loader_checker i_chk (.clk, .reset, .flashReadStrobe, .flashReadAddr,
	.tableRead, .tableData, .loadDone, .deviceResetRelease, .wholeCodeProtect,
	.wholeWriteProtect, .watchdogPrescale, .watchdogPostscale, .primaryOscMode);
